// ### rtl/nfs_regs.svh
/*
  Constants of the feature and status host controller: command codes, feature selectors,
  status field positions, power-on values of the feature settings and the bus timing counts.
  Assumes a 25 MHz controller clock. Definitions only; included by bare name.
*/
`ifndef NFS_REGS_SVH
`define NFS_REGS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define NFS_CMD_READ_MODE 8'h00
`define NFS_CMD_STATUS 8'h70
`define NFS_CMD_STATUS_ADDR 8'h78
`define NFS_CMD_FEAT_READ 8'hEE
`define NFS_CMD_FEAT_WRITE 8'hEF

// ----------------------------------------------------------------------
// Feature selectors of the device and their power-on values
// ----------------------------------------------------------------------
`define NFS_SEL_INTERFACE_TIMING_MODE 8'h01
`define NFS_SEL_OUTPUT_DRIVE_STRENGTH 8'h80
`define NFS_SEL_BUSY_PIN_PULLDOWN_STRENGTH 8'h81
`define NFS_RST_INTERFACE_TIMING_MODE 8'h00
`define NFS_RST_OUTPUT_DRIVE_STRENGTH 8'h00
`define NFS_RST_BUSY_PIN_PULLDOWN_STRENGTH 8'h00

// ----------------------------------------------------------------------
// Fields of status_byte
// ----------------------------------------------------------------------
`define NFS_SR_WP_N_BIT 7
`define NFS_SR_READY_BIT 6
`define NFS_SR_ARRAY_IDLE_BIT 5
`define NFS_SR_PRIOR_FAIL_BIT 1
`define NFS_SR_FAIL_BIT 0

// ----------------------------------------------------------------------
// Timing: times in ns, counts derived at the clock period
// ----------------------------------------------------------------------
`define NFS_CLK_NS 40
`define NFS_STROBE_NS 50
`define NFS_TWB_NS 100
`define NFS_TADL_NS 70
`define NFS_TWHR_NS 60
`define NFS_STROBE_CYC ((`NFS_STROBE_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_TWB_CYC ((`NFS_TWB_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_TADL_CYC ((`NFS_TADL_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_TWHR_CYC ((`NFS_TWHR_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_BUSY_TMO_CYC 4000

`endif

// ### rtl/nfs_pkg.sv
/*
  Types of the feature and status host controller: user operations and sequencer states.
  Assumes nfs_regs.svh supplies the numeric constants.
*/
package nfs_pkg;

  // User operations
  typedef enum logic [1:0] {
    NFS_OP_FEAT_READ = 2'b00,
    NFS_OP_FEAT_WRITE = 2'b01,
    NFS_OP_STATUS = 2'b10,
    NFS_OP_STATUS_ADDR = 2'b11
  } nfs_op_t;

  // Sequencer states
  typedef enum logic [3:0] {
    NFS_ST_IDLE = 4'b0000,
    NFS_ST_CMD = 4'b0001,
    NFS_ST_ADDR = 4'b0010,
    NFS_ST_ADL = 4'b0011,
    NFS_ST_WDAT = 4'b0100,
    NFS_ST_BUSY = 4'b0101,
    NFS_ST_WHR = 4'b0110,
    NFS_ST_POLL = 4'b0111,
    NFS_ST_RDAT = 4'b1000,
    NFS_ST_DONE = 4'b1001
  } nfs_state_t;

endpackage

// ### rtl/nfs_sync.sv
/*
  Two-flop synchroniser for pin inputs, width set by parameter.
  Assumes the input is asynchronous to clk; the first flop feeds only the second.
*/
`timescale 1ns/100ps
module nfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // Two stages; reset value is a constant
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // nfs_sync

// ### rtl/nfs_host.sv
/*
  Host controller that drives an asynchronous NAND target for feature read, feature write,
  plain status and addressed status. Orders come on a plain user port; results return there.
  Assumes the IO bus wire is resolved outside from nand_io_oe, and that R/B# is pulled up.
*/
// How it works
// - Feature access only when target idle
// - After 70h polling, issue 00h before reading
// - Never issue 78h during feature read
// - After access time, read the parameter bytes
// - Feature-read polling ends with 00h command
// - Multi-die status uses addressed status 78h
// - Feature write: selector, wait, four bytes
// - 78h is followed by three row bytes
`timescale 1ns/100ps
`include "nfs_regs.svh"
module nfs_host #(
  parameter int BUSY_TMO = `NFS_BUSY_TMO_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic start,
  input wire nfs_pkg::nfs_op_t op,
  input wire logic [7:0] feat_sel,
  input wire logic [31:0] wr_params,
  input wire logic [23:0] row_addr,
  input wire logic poll_status,
  input wire logic multi_die,
  input wire logic write_protect,
  output logic busy,
  output logic done,
  output logic err,
  output logic [31:0] rd_params,
  output logic [7:0] status_byte,
  output logic nand_ce_n,
  output logic nand_cle,
  output logic nand_ale,
  output logic nand_we_n,
  output logic nand_re_n,
  output logic nand_wp_n,
  output logic [7:0] nand_io_out,
  output logic nand_io_oe,
  input wire logic [7:0] nand_io_in,
  input wire logic nand_busy_n
);

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam logic [4:0] PH = 5'(`NFS_STROBE_CYC);
  localparam logic [4:0] RLO = 5'(`NFS_STROBE_CYC + 3); // Covers sync latency plus access
  localparam logic [4:0] WLEN = 5'(2 * `NFS_STROBE_CYC);
  localparam logic [4:0] RLEN = 5'(2 * `NFS_STROBE_CYC + 3);
  localparam logic [15:0] TWB = 16'(`NFS_TWB_CYC);
  localparam logic [15:0] TADL = 16'(`NFS_TADL_CYC);
  localparam logic [15:0] TWHR = 16'(`NFS_TWHR_CYC);
  localparam logic [15:0] TMO = 16'(BUSY_TMO);

  nfs_pkg::nfs_state_t state_r, state_nxt;
  nfs_pkg::nfs_op_t op_r;
  logic [7:0] cmd_r, cmd_nxt, sel_r, io_s, byte_now, sample_r;
  logic [31:0] wpar_r;
  logic [23:0] row_r;
  logic poll_r, rb_s, wr_st, rd_st, last_ph, sample_now;
  logic [4:0] ph_r;
  logic [1:0] cnt_r;
  logic [15:0] tmr_r;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  nfs_sync #(.WIDTH(8)) u_io_sync (
    .clk(clk), .reset(reset), .clk_en(clk_en), .async_in(nand_io_in), .sync_out(io_s)
  );
  nfs_sync #(.WIDTH(1)) u_rb_sync (
    .clk(clk), .reset(reset), .clk_en(clk_en), .async_in(nand_busy_n), .sync_out(rb_s)
  );

  // Phase decode of the current bus cycle
  assign wr_st = (state_r == nfs_pkg::NFS_ST_CMD) || (state_r == nfs_pkg::NFS_ST_ADDR) ||
                 (state_r == nfs_pkg::NFS_ST_WDAT);
  assign rd_st = (state_r == nfs_pkg::NFS_ST_POLL) || (state_r == nfs_pkg::NFS_ST_RDAT);
  assign last_ph = wr_st ? (ph_r == WLEN - 5'd1) : (ph_r == RLEN - 5'd1);
  assign sample_now = rd_st && (ph_r == RLO - 5'd1);

  // Byte driven in a write cycle; 78h row bytes go out low byte first
  always_comb begin
    byte_now = cmd_r;
    if (state_r == nfs_pkg::NFS_ST_ADDR) begin
      byte_now = (op_r == nfs_pkg::NFS_OP_STATUS_ADDR) ? row_r[8*cnt_r +: 8] : sel_r;
    end else if (state_r == nfs_pkg::NFS_ST_WDAT) begin
      byte_now = wpar_r[8*cnt_r +: 8];
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    unique case (state_r)
      nfs_pkg::NFS_ST_IDLE: begin
        if (start) begin
          if ((op == nfs_pkg::NFS_OP_FEAT_READ || op == nfs_pkg::NFS_OP_FEAT_WRITE) && !rb_s) begin
            state_nxt = nfs_pkg::NFS_ST_IDLE; // Refused while busy
          end else begin
            state_nxt = nfs_pkg::NFS_ST_CMD;
            unique case (op)
              nfs_pkg::NFS_OP_FEAT_READ: cmd_nxt = `NFS_CMD_FEAT_READ;
              nfs_pkg::NFS_OP_FEAT_WRITE: cmd_nxt = `NFS_CMD_FEAT_WRITE;
              nfs_pkg::NFS_OP_STATUS: cmd_nxt = multi_die ? `NFS_CMD_STATUS_ADDR : `NFS_CMD_STATUS;
              nfs_pkg::NFS_OP_STATUS_ADDR: cmd_nxt = `NFS_CMD_STATUS_ADDR;
            endcase
          end
        end
      end
      nfs_pkg::NFS_ST_CMD: begin
        if (last_ph) begin
          if (cmd_r == `NFS_CMD_FEAT_READ || cmd_r == `NFS_CMD_FEAT_WRITE ||
              cmd_r == `NFS_CMD_STATUS_ADDR) begin
            state_nxt = nfs_pkg::NFS_ST_ADDR;
          end else begin
            state_nxt = nfs_pkg::NFS_ST_WHR;
          end
        end
      end
      nfs_pkg::NFS_ST_ADDR: begin
        if (last_ph) begin
          if (op_r == nfs_pkg::NFS_OP_STATUS_ADDR) begin
            state_nxt = (cnt_r == 2'd2) ? nfs_pkg::NFS_ST_WHR : nfs_pkg::NFS_ST_ADDR;
          end else if (op_r == nfs_pkg::NFS_OP_FEAT_WRITE) begin
            state_nxt = nfs_pkg::NFS_ST_ADL;
          end else begin
            state_nxt = nfs_pkg::NFS_ST_BUSY;
          end
        end
      end
      nfs_pkg::NFS_ST_ADL: begin
        if (tmr_r >= TADL - 16'd1) state_nxt = nfs_pkg::NFS_ST_WDAT;
      end
      nfs_pkg::NFS_ST_WDAT: begin
        if (last_ph && cnt_r == 2'd3) state_nxt = nfs_pkg::NFS_ST_BUSY;
      end
      nfs_pkg::NFS_ST_BUSY: begin
        // R/B# is ignored for tWB, since the target needs that long to pull it low
        if (tmr_r >= TWB) begin
          if (poll_r && op_r == nfs_pkg::NFS_OP_FEAT_READ) begin
            state_nxt = nfs_pkg::NFS_ST_CMD;
            cmd_nxt = `NFS_CMD_STATUS;
          end else if (rb_s) begin
            state_nxt = (op_r == nfs_pkg::NFS_OP_FEAT_READ) ? nfs_pkg::NFS_ST_WHR : nfs_pkg::NFS_ST_DONE;
          end else if (tmr_r >= TMO) begin
            state_nxt = nfs_pkg::NFS_ST_DONE;
          end
        end
      end
      nfs_pkg::NFS_ST_WHR: begin
        if (tmr_r >= TWHR - 16'd1) begin
          state_nxt = (cmd_r == `NFS_CMD_STATUS && op_r == nfs_pkg::NFS_OP_FEAT_READ) ?
                      nfs_pkg::NFS_ST_POLL : nfs_pkg::NFS_ST_RDAT;
        end
      end
      nfs_pkg::NFS_ST_POLL: begin
        if (last_ph && sample_r[`NFS_SR_READY_BIT]) begin
          state_nxt = nfs_pkg::NFS_ST_CMD;
          cmd_nxt = `NFS_CMD_READ_MODE; // Restore data output
        end else if (tmr_r >= TMO) begin
          state_nxt = nfs_pkg::NFS_ST_DONE;
        end
      end
      nfs_pkg::NFS_ST_RDAT: begin
        if (last_ph && (op_r != nfs_pkg::NFS_OP_FEAT_READ || cnt_r == 2'd3)) begin
          state_nxt = nfs_pkg::NFS_ST_DONE; // Four parameter bytes
        end
      end
      nfs_pkg::NFS_ST_DONE: state_nxt = nfs_pkg::NFS_ST_IDLE;
      default: state_nxt = nfs_pkg::NFS_ST_IDLE; // Unused codes
    endcase
  end

  // State, captured order and command byte
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= nfs_pkg::NFS_ST_IDLE;
      cmd_r <= 8'h00;
      op_r <= nfs_pkg::NFS_OP_FEAT_READ;
      sel_r <= 8'h00;
      wpar_r <= 32'h0000_0000;
      row_r <= 24'h00_0000;
      poll_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      if (state_r == nfs_pkg::NFS_ST_IDLE && start) begin
        op_r <= (op == nfs_pkg::NFS_OP_STATUS && multi_die) ? nfs_pkg::NFS_OP_STATUS_ADDR : op;
        sel_r <= feat_sel;
        wpar_r <= wr_params;
        row_r <= row_addr;
        poll_r <= poll_status;
      end
    end
  end

  // Phase, byte index and time-in-state counters
  always_ff @(posedge clk) begin
    if (reset) begin
      ph_r <= 5'd0;
      cnt_r <= 2'd0;
      tmr_r <= 16'h0000;
    end else if (clk_en) begin
      ph_r <= (last_ph || !(wr_st || rd_st)) ? 5'd0 : ph_r + 5'd1;
      if (state_nxt != state_r) begin
        cnt_r <= 2'd0;
        tmr_r <= 16'h0000;
      end else begin
        if (last_ph) cnt_r <= cnt_r + 2'd1;
        if (tmr_r != 16'hFFFF) tmr_r <= tmr_r + 16'd1;
      end
    end
  end

  // Sampled bytes: parameters land low byte first
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_r <= 8'h00;
      rd_params <= 32'h0000_0000;
      status_byte <= 8'h00;
    end else if (clk_en && sample_now) begin
      sample_r <= io_s;
      if (state_r == nfs_pkg::NFS_ST_POLL || op_r != nfs_pkg::NFS_OP_FEAT_READ) begin
        status_byte <= io_s;
      end else begin
        rd_params[8*cnt_r +: 8] <= io_s;
      end
    end
  end

  // User handshake: done and err are one-cycle pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
    end else if (clk_en) begin
      busy <= (state_nxt != nfs_pkg::NFS_ST_IDLE);
      done <= (state_nxt == nfs_pkg::NFS_ST_DONE);
      err <= (state_r == nfs_pkg::NFS_ST_IDLE && start && state_nxt == nfs_pkg::NFS_ST_IDLE) ||
             (state_nxt == nfs_pkg::NFS_ST_DONE && tmr_r >= TMO);
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers, all registered
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      nand_ce_n <= 1'b1;
      nand_cle <= 1'b0;
      nand_ale <= 1'b0;
      nand_we_n <= 1'b1;
      nand_re_n <= 1'b1;
      nand_wp_n <= 1'b0;
      nand_io_out <= 8'h00;
      nand_io_oe <= 1'b0;
    end else if (clk_en) begin
      nand_ce_n <= (state_r == nfs_pkg::NFS_ST_IDLE) || (state_r == nfs_pkg::NFS_ST_DONE);
      nand_cle <= (state_r == nfs_pkg::NFS_ST_CMD);
      nand_ale <= (state_r == nfs_pkg::NFS_ST_ADDR);
      nand_we_n <= !(wr_st && ph_r < PH); // Data latched at the rising edge
      nand_re_n <= !(rd_st && ph_r < RLO);
      nand_wp_n <= !write_protect;
      nand_io_out <= byte_now;
      nand_io_oe <= wr_st;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !clk_en);

  AST_NO_ADDR_STATUS_IN_FEAT_READ: assert property (
    (nand_cle && !nand_we_n && op_r == nfs_pkg::NFS_OP_FEAT_READ) |-> nand_io_out != `NFS_CMD_STATUS_ADDR
  ) else $error("78h issued during feature read");

  AST_REFUSE_WHEN_BUSY: assert property (
    (state_r == nfs_pkg::NFS_ST_IDLE && start && !rb_s &&
     (op == nfs_pkg::NFS_OP_FEAT_READ || op == nfs_pkg::NFS_OP_FEAT_WRITE))
    |=> (state_r == nfs_pkg::NFS_ST_IDLE && err)
  ) else $error("feature access not refused while busy");

  AST_READ_MODE_AFTER_POLL: assert property (
    (state_r == nfs_pkg::NFS_ST_POLL && state_nxt != nfs_pkg::NFS_ST_POLL && state_nxt != nfs_pkg::NFS_ST_DONE)
    |=> (state_r == nfs_pkg::NFS_ST_CMD && cmd_r == `NFS_CMD_READ_MODE)
  ) else $error("no 00h after status polling");

  AST_ADL_BEFORE_DATA: assert property (
    $rose(state_r == nfs_pkg::NFS_ST_WDAT) |-> $past(state_r) == nfs_pkg::NFS_ST_ADL
  ) else $error("parameter data without address-to-data wait");

  AST_FOUR_PARAMS: assert property (
    (state_r == nfs_pkg::NFS_ST_RDAT && op_r == nfs_pkg::NFS_OP_FEAT_READ && last_ph && cnt_r != 2'd3)
    |=> state_r == nfs_pkg::NFS_ST_RDAT
  ) else $error("feature read ended before four bytes");

  AST_THREE_ROW_BYTES: assert property (
    (state_r == nfs_pkg::NFS_ST_ADDR && op_r == nfs_pkg::NFS_OP_STATUS_ADDR && last_ph && cnt_r != 2'd2)
    |=> state_r == nfs_pkg::NFS_ST_ADDR
  ) else $error("addressed status sent fewer than three row bytes");

  AST_IO_STABLE_IN_STROBE: assert property (
    (!nand_we_n && !$fell(nand_we_n)) |-> (nand_io_oe && $stable(nand_io_out))
  ) else $error("IO changed while write strobe low");

  AST_STROBES_EXCLUSIVE: assert property (
    !(!nand_we_n && !nand_re_n) && !(!nand_re_n && nand_io_oe)
  ) else $error("read and write strobe overlap");

  AST_MULTI_DIE_ADDRESSED: assert property (
    (state_r == nfs_pkg::NFS_ST_IDLE && start && op == nfs_pkg::NFS_OP_STATUS && multi_die)
    |=> (op_r == nfs_pkg::NFS_OP_STATUS_ADDR && cmd_r == `NFS_CMD_STATUS_ADDR)
  ) else $error("multi-die status not addressed");

  AST_WAIT_TWB: assert property (
    $rose(state_r == nfs_pkg::NFS_ST_BUSY) |-> (state_r == nfs_pkg::NFS_ST_BUSY) [*3]
  ) else $error("busy wait shorter than tWB");

  COV_FEAT_READ: cover property (state_r == nfs_pkg::NFS_ST_RDAT && op_r == nfs_pkg::NFS_OP_FEAT_READ ##[1:200] done);
  COV_POLLED_READ: cover property (state_r == nfs_pkg::NFS_ST_POLL ##[1:300] cmd_r == `NFS_CMD_READ_MODE);
  COV_FEAT_WRITE: cover property (state_r == nfs_pkg::NFS_ST_WDAT ##[1:300] state_r == nfs_pkg::NFS_ST_DONE);
  COV_ADDR_STATUS: cover property (op_r == nfs_pkg::NFS_OP_STATUS_ADDR && done);

endmodule // nfs_host

// ### verification/nfs_dev_model.sv
/*
  Behavioural model of the NAND target: feature store, feature busy time, per-die status.
  Assumes the bench resolves the shared IO wire and pulses power_cycle before first use.
*/
`timescale 1ns/100ps
`include "nfs_regs.svh"
module nfs_dev_model #(
  parameter int FEAT_NS = 800
) (
  input wire logic power_cycle,
  input wire logic hold_busy,
  input wire logic [3:0] die_fail,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic busy_n
);
  logic [7:0] cmd_r, sel_r, lat_io;
  logic [31:0] feat_r [3];
  logic [31:0] win_r, out_r;
  logic [1:0] idx_r, cnt_r;
  logic lat_cyc, lat_cle, lat_ale, smode_r, die_r, rdy_r, rdy;
  event kick;

  // ------
  // Feature store
  // ------
  function automatic logic [31:0] peek(input logic [7:0] s);
    case (s)
      8'h01: peek = feat_r[0];
      8'h80: peek = feat_r[1];
      8'h81: peek = feat_r[2];
      default: peek = 32'h0000_0000;
    endcase
  endfunction

  // Power cycle brings every setting back to its power-on value
  always @(posedge power_cycle) begin
    feat_r[0] = {24'h00_0000, `NFS_RST_INTERFACE_TIMING_MODE};
    feat_r[1] = {24'h00_0000, `NFS_RST_OUTPUT_DRIVE_STRENGTH};
    feat_r[2] = {24'h00_0000, `NFS_RST_BUSY_PIN_PULLDOWN_STRENGTH};
    cmd_r = 8'h00;
    smode_r = 1'b0;
    die_r = 1'b0;
    rdy_r = 1'b1;
  end

  // Bus is looked at 10 ns after the write strobe falls, well before its rising edge
  always @(negedge we_n) begin
    #10;
    {lat_cyc, lat_cle, lat_ale, lat_io} = {!ce_n, cle, ale, io_in};
  end

  // Command, address and data cycles take effect at the rising write strobe
  always @(posedge we_n) begin
    if (lat_cyc && lat_cle) begin
      cmd_r = lat_io;
      cnt_r = 2'd0;
      smode_r = lat_io == 8'h70 || lat_io == 8'h78;
    end else if (lat_cyc && lat_ale && cmd_r == 8'hee) begin
      out_r = peek(lat_io);
      idx_r = 2'd0;
      ->kick;
    end else if (lat_cyc && lat_ale && cmd_r == 8'hef) begin
      sel_r = lat_io;
    end else if (lat_cyc && lat_ale && cmd_r == 8'h78) begin
      if (cnt_r == 2'd2) die_r = lat_io[0];
      cnt_r = cnt_r + 2'd1;
    end else if (lat_cyc && cmd_r == 8'hef) begin
      win_r[8*cnt_r +: 8] = lat_io;
      cnt_r = cnt_r + 2'd1;
      if (cnt_r == 2'd0) begin
        case (sel_r)
          8'h01: feat_r[0] = {{29{1'b0}}, win_r[2:0]};
          8'h80: feat_r[1] = {{30{1'b0}}, win_r[1:0]};
          8'h81: feat_r[2] = {{30{1'b0}}, win_r[1:0]};
          default: ;
        endcase
        ->kick;
      end
    end
  end

  // Feature access time: busy first, ready after; strobes still land meanwhile
  always begin
    @(kick);
    rdy_r = 1'b0;
    #FEAT_NS;
    rdy_r = 1'b1;
  end

  // Each read strobe hands over the next parameter byte, first to fourth
  always @(posedge re_n) begin
    if (!ce_n && !smode_r) idx_r = idx_r + 2'd1;
  end

  // Status tracks its sources while the read strobe stays low
  assign rdy = rdy_r && !hold_busy;
  assign busy_n = rdy;
  assign io_oe = !ce_n && !re_n;
  assign io_out = smode_r ? {wp_n, rdy, rdy, 3'b000, die_fail[2*die_r +: 2]}
                          : out_r[8*idx_r +: 8];
endmodule  // nfs_dev_model

// ### verification/nfs_host_test.sv
/*
  Self-checking bench of the feature and status host controller against the target model.
  Assumes the design files and nfs_dev_model are compiled first, rtl/ on the include path.
*/
`timescale 1ns/100ps
module nfs_host_test;
  logic clk, reset, start, poll_status, multi_die, write_protect, power_cycle, hold_busy, seen_err;
  logic busy, done, err, ce_n, cle, ale, we_n, re_n, wp_n, host_oe, dev_oe, busy_n;
  nfs_pkg::nfs_op_t op;
  logic [7:0] feat_sel, host_io, dev_io, status_byte;
  logic [7:0] last_io = 8'h00;
  logic [7:0] sels [4] = '{8'h01, 8'h80, 8'h81, 8'h00};
  logic [31:0] wr_params, rd_params;
  logic [31:0] shadow [4];
  logic [23:0] row_addr;
  logic [3:0] die_fail;
  wire logic [7:0] io_bus;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  // A released bus shows the inverse of its last level, never a stale copy
  assign io_bus = host_oe ? host_io : (dev_oe ? dev_io : ~last_io);
  always @(posedge clk) begin
    if (host_oe || dev_oe) last_io <= io_bus;
  end

  nfs_host u_dut (
    .clk(clk), .reset(reset), .clk_en(1'b1), .start(start), .op(op), .feat_sel(feat_sel),
    .wr_params(wr_params), .row_addr(row_addr), .poll_status(poll_status), .multi_die(multi_die),
    .write_protect(write_protect), .busy(busy), .done(done), .err(err), .rd_params(rd_params),
    .status_byte(status_byte), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
    .nand_re_n(re_n), .nand_wp_n(wp_n), .nand_io_out(host_io), .nand_io_oe(host_oe),
    .nand_io_in(io_bus), .nand_busy_n(busy_n)
  );
  nfs_dev_model u_dev (
    .power_cycle(power_cycle), .hold_busy(hold_busy), .die_fail(die_fail), .ce_n(ce_n), .cle(cle),
    .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_in(io_bus), .io_out(dev_io), .io_oe(dev_oe),
    .busy_n(busy_n)
  );

  // ------
  // Expectations and shared tasks
  // ------
  function automatic logic [31:0] feat_exp(input logic [7:0] s, input logic [31:0] w);
    case (s)
      8'h01: feat_exp = {{29{1'b0}}, w[2:0]};
      8'h80, 8'h81: feat_exp = {{30{1'b0}}, w[1:0]};
      default: feat_exp = 32'h0000_0000;
    endcase
  endfunction
  function automatic int slot(input logic [7:0] s);
    slot = s == 8'h01 ? 0 : (s == 8'h80 ? 1 : (s == 8'h81 ? 2 : 3));
  endfunction
  function automatic logic [7:0] sr_exp(input logic wp, input logic rdy, input logic [1:0] f);
    sr_exp = {~wp, rdy, rdy, 3'b000, f};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One user request, then wait for its end; the wait is bounded
  task automatic run(input nfs_pkg::nfs_op_t o, input logic [7:0] s, input logic [31:0] w, input logic p);
    int n;
    logic refuse;
    @(posedge clk);
    op <= o;
    feat_sel <= s;
    wr_params <= w;
    poll_status <= p;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    #1;
    // A refusal pulses err at the very edge that takes start, so it is looked at here first
    seen_err = (err === 1'b1);
    refuse = hold_busy && (o == nfs_pkg::NFS_OP_FEAT_READ || o == nfs_pkg::NFS_OP_FEAT_WRITE);
    check(busy, !refuse);
    do begin
      @(posedge clk);
      #1;
      n++;
      if (err === 1'b1) seen_err = 1'b1;
    end while (done !== 1'b1 && !seen_err && n < 3000);
    if (n >= 3000) miscompares++;
  endtask

  task automatic rd_chk(input logic [7:0] s, input logic p);
    run(nfs_pkg::NFS_OP_FEAT_READ, s, 32'($urandom), p);
    check(rd_params, shadow[slot(s)]);
  endtask

  // Power cycle of the target; every setting returns to its default
  task automatic pwr();
    @(posedge clk);
    power_cycle <= 1'b1;
    @(posedge clk);
    power_cycle <= 1'b0;
    shadow = '{default: 32'h0000_0000};
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Watchdog: a hung handshake ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    logic [7:0] s;
    logic [31:0] w;
    {reset, start, poll_status, multi_die, write_protect, power_cycle, hold_busy} = 7'b100_0000;
    op = nfs_pkg::NFS_OP_STATUS;
    feat_sel = 8'h00;
    wr_params = 32'h0000_0000;
    row_addr = 24'h00_0000;
    die_fail = 4'h0;
    void'($urandom(32'h057d_71e2));
    pwr();
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    // Power-on values, read by pin and by polling
    for (int i = 0; i < 4; i++) rd_chk(sels[i], i[0]);
    // Random writes and read-backs, reserved selectors among them
    for (int i = 0; i < 12; i++) begin
      s = sels[$urandom_range(3, 0)];
      if (s == 8'h00) s = 8'($urandom_range(8'h7f, 8'h02));
      w = $urandom;
      w[2] = 1'b0;  // Timing modes above 3 are not offered
      run(nfs_pkg::NFS_OP_FEAT_WRITE, s, w, 1'b0);
      shadow[slot(s)] = feat_exp(s, w);
      rd_chk(s, i[0]);
    end
    pwr();
    for (int i = 0; i < 3; i++) rd_chk(sels[i], 1'b0);
    // Status of each die, addressed first, then by the plain command
    for (int i = 0; i < 4; i++) begin
      write_protect <= i[0];
      die_fail <= 4'($urandom);
      row_addr <= {7'h00, i[1], 16'h0000};
      multi_die <= i[0];
      run(i[0] ? nfs_pkg::NFS_OP_STATUS : nfs_pkg::NFS_OP_STATUS_ADDR, 8'h00, 32'h0000_0000, 1'b0);
      check(status_byte, sr_exp(i[0], 1'b1, die_fail[2*i[1] +: 2]));
      multi_die <= 1'b0;
      run(nfs_pkg::NFS_OP_STATUS, 8'h00, 32'h0000_0000, 1'b0);
      check(status_byte, sr_exp(i[0], 1'b1, die_fail[2*i[1] +: 2]));
    end
    // Busy target: status shows busy, a feature read is refused
    hold_busy <= 1'b1;
    run(nfs_pkg::NFS_OP_STATUS, 8'h00, 32'h0000_0000, 1'b0);
    check(status_byte, sr_exp(write_protect, 1'b0, die_fail[3:2]));
    run(nfs_pkg::NFS_OP_FEAT_READ, 8'h01, 32'h0000_0000, 1'b0);
    check(seen_err, 1'b1);
    hold_busy <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(8'h80, 1'b1);
    finish_test();
  end
endmodule  // nfs_host_test
